// File: rtl/clk_ctrl_defs.svh
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_LOCK_STATUS 16'hF027
`define IDX_POWER_ENABLE 16'hF050
`define IDX_IRQ_STATUS 16'hF060
`define IDX_IRQ_MASK 16'hF061

// field positions
`define BIT_LOCK 0
`define BIT_GEN1_PWR 10
`define BIT_GEN2_PWR 11
`define BIT_GEN3_PWR 12
`define BIT_EV_LOCK_GAIN 0
`define BIT_EV_LOCK_LOSS 1

// reset values
`define RST_LOCK_STATUS 16'h0000
`define RST_LOCK_BIT 1'h0
`define RST_POWER_ENABLE 16'h0000
`define RST_IRQ 2'h0

`endif

// File: rtl/clk_ctrl_pkg.sv
`default_nettype none

package clk_ctrl_pkg;

  typedef enum logic [1:0] {SRC_SYS, SRC_GEN1, SRC_GEN2, SRC_GEN3} clk_src_t;
  typedef logic [15:0] reg16_t;
  // bit 0 is the first generator
  typedef logic [2:0] gen_vec_t;

  // a function on the system clock always runs
  function automatic logic genOn(input clk_src_t src, input gen_vec_t pwr);
    unique case (src)
      SRC_SYS: genOn = 1'b1;
      SRC_GEN1: genOn = pwr[0];
      SRC_GEN2: genOn = pwr[1];
      SRC_GEN3: genOn = pwr[2];
    endcase
  endfunction : genOn

  // a pin not fed by a generator stays low
  function automatic logic clkOf(input clk_src_t src, input gen_vec_t clk, input gen_vec_t pwr);
    unique case (src)
      SRC_SYS: clkOf = 1'b0;
      SRC_GEN1: clkOf = clk[0] & pwr[0];
      SRC_GEN2: clkOf = clk[1] & pwr[1];
      SRC_GEN3: clkOf = clk[2] & pwr[2];
    endcase
  endfunction : clkOf

endpackage : clk_ctrl_pkg

`default_nettype wire

// File: rtl/sync3.sv
`default_nettype none

module sync3 (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // level
  input wire logic din,
  output logic dout
);

  logic ff1;
  logic ff2;
  logic ff3;

  // ff1 is seen only by ff2; a change counts once ff2 and ff3 agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      ff1 <= din;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3) begin
        dout <= ff3;
      end
    end
  end

endmodule : sync3

`default_nettype wire

// File: rtl/clk_pin_gate.sv
`default_nettype none

module clk_pin_gate
  import clk_ctrl_pkg::*;
#(
  parameter int NPINS = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // generator clocks, already synchronised, and power
  input wire clk_ctrl_pkg::gen_vec_t genClk,
  input wire clk_ctrl_pkg::gen_vec_t genPower,
  // per pin source, two bits each
  input wire logic [2*NPINS-1:0] pinSrc,
  output logic [NPINS-1:0] pinOut
);

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          pinOut[i] <= 1'b0;
        end else if (ce) begin
          pinOut[i] <= clkOf(clk_src_t'(pinSrc[2*i+:2]), genClk, genPower);
        end
      end
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // every pin is watched, not only pin 0, so any source map that puts a pin on the first or second generator exercises the checks
  genvar j;
  generate
    for (j = 0; j < NPINS; j++) begin : g_pin_chk
      AST_PIN_GEN2_LOW: assert property (
        ce && clk_src_t'(pinSrc[2*j+:2]) == SRC_GEN2 && !genPower[1] |=> !pinOut[j])
        else $error("pin fed by stopped second generator not low");

      AST_PIN_GEN1_LOW: assert property (
        ce && clk_src_t'(pinSrc[2*j+:2]) == SRC_GEN1 && !genPower[0] |=> !pinOut[j])
        else $error("pin fed by stopped first generator not low");
    end
  endgenerate

endmodule : clk_pin_gate

`default_nettype wire

// File: rtl/audio_clock_gen_power_lock.sv
`include "clk_ctrl_defs.svh"
`default_nettype none

module audio_clock_gen_power_lock
  import clk_ctrl_pkg::*;
#(
  parameter int NPINS = 4,
  parameter int NFUNC = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [17:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic wbAck,
  output logic [31:0] wbDatO,
  // clock generators
  input wire logic thirdGenLocked,
  input wire clk_ctrl_pkg::gen_vec_t genFrameClk,
  input wire clk_ctrl_pkg::gen_vec_t genBitClk,
  output logic firstGenPowerOn,
  output logic secondGenPowerOn,
  output logic thirdGenPowerOn,
  // clock pins
  input wire logic [2*NPINS-1:0] frameClockSrc,
  input wire logic [2*NPINS-1:0] bitClockSrc,
  output logic [NPINS-1:0] frameClockOutPin,
  output logic [NPINS-1:0] bitClockOutPin,
  // hardware functions, index 0 is the dsp core
  input wire logic [2*NFUNC-1:0] funcClkSrc,
  output logic [NFUNC-1:0] funcRun,
  // interrupt
  output logic irq
);

  import clk_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg16_t powerEnable;
  logic lockStatus;
  logic next_lockStatus;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [1:0] lockEvents;
  logic lockSync;
  gen_vec_t frameSync;
  gen_vec_t bitSync;
  gen_vec_t genPower;
  logic busReq;
  logic busWrite;
  logic [31:0] readData;
  logic [15:0] wrMask;

  // decode shared by the read and write paths
  function automatic logic hit(input logic [17:0] adr, input logic [15:0] idx);
    hit = (adr[17:2] == idx);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for everything coming from the generators

  sync3 u_lock_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .din(thirdGenLocked),
    .dout(lockSync)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_clk_sync
      sync3 u_frame_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .din(genFrameClk[g]),
        .dout(frameSync[g])
      );
      sync3 u_bit_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .din(genBitClk[g]),
        .dout(bitSync[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  // one cycle answer; the write lands on the edge where ack is seen
  assign busReq = wbCyc & wbStb & ~wbAck;
  assign busWrite = wbCyc & wbStb & wbWe & wbAck;
  assign wrMask = {{8{wbSel[1]}}, {8{wbSel[0]}}};

  // lock bit at bit 0, power enable at 15:0, irq status and mask at 1:0, rest zero
  always_comb begin
    readData = 32'h0000_0000;
    if (hit(wbAdr, `IDX_LOCK_STATUS)) begin
      readData[`BIT_LOCK] = lockStatus;
    end else if (hit(wbAdr, `IDX_POWER_ENABLE)) begin
      readData[15:0] = powerEnable;
    end else if (hit(wbAdr, `IDX_IRQ_STATUS)) begin
      readData[1:0] = irqStatus;
    end else if (hit(wbAdr, `IDX_IRQ_MASK)) begin
      readData[1:0] = irqMask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wbAck <= 1'b0;
    end else if (ce) begin
      wbAck <= busReq;
    end
  end

  // unmapped addresses answer with zero data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wbDatO <= 32'h0000_0000;
    end else if (ce && busReq && !wbWe) begin
      wbDatO <= readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power enable register

  // cleared at reset, all generators off
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      powerEnable <= `RST_POWER_ENABLE;
    end else if (ce && busWrite && hit(wbAdr, `IDX_POWER_ENABLE)) begin
      powerEnable <= (powerEnable & ~wrMask) | (wbDatI[15:0] & wrMask);
    end
  end

  // first generator enable from bit 10
  assign firstGenPowerOn = powerEnable[`BIT_GEN1_PWR];
  assign secondGenPowerOn = powerEnable[`BIT_GEN2_PWR];
  assign thirdGenPowerOn = powerEnable[`BIT_GEN3_PWR];
  assign genPower = {thirdGenPowerOn, secondGenPowerOn, firstGenPowerOn};

  ////////////////////////////////////////////////////////////////////////////
  // lock status

  // independent of the reference choice
  // a stopped generator cannot be locked, so power masks the raw lock
  assign next_lockStatus = lockSync & thirdGenPowerOn;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lockStatus <= `RST_LOCK_BIT;
    end else if (ce) begin
      lockStatus <= next_lockStatus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock pins

  clk_pin_gate #(
    .NPINS(NPINS)
  ) u_frame_pins (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .genClk(frameSync),
    .genPower(genPower),
    .pinSrc(frameClockSrc),
    .pinOut(frameClockOutPin)
  );

  clk_pin_gate #(
    .NPINS(NPINS)
  ) u_bit_pins (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .genClk(bitSync),
    .genPower(genPower),
    .pinSrc(bitClockSrc),
    .pinOut(bitClockOutPin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // function run enables

  genvar f;
  generate
    for (f = 0; f < NFUNC; f++) begin : g_func
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          funcRun[f] <= 1'b0;
        end else if (ce) begin
          funcRun[f] <= genOn(clk_src_t'(funcClkSrc[2*f+:2]), genPower);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign lockEvents[`BIT_EV_LOCK_GAIN] = next_lockStatus & ~lockStatus;
  assign lockEvents[`BIT_EV_LOCK_LOSS] = ~next_lockStatus & lockStatus;

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqStatus <= `RST_IRQ;
    end else if (ce) begin
      if (busWrite && hit(wbAdr, `IDX_IRQ_STATUS) && wbSel[0]) begin
        irqStatus <= (irqStatus & ~wbDatI[1:0]) | lockEvents;
      end else begin
        irqStatus <= irqStatus | lockEvents;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irqMask <= `RST_IRQ;
    end else if (ce && busWrite && hit(wbAdr, `IDX_IRQ_MASK) && wbSel[0]) begin
      irqMask <= wbDatI[1:0];
    end
  end

  // registered, so irq trails the status bit by one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irqStatus & irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_LOCK_READ: assert property (
    ce && busReq && !wbWe && hit(wbAdr, `IDX_LOCK_STATUS)
    |=> wbAck && wbDatO == {31'h0000_0000, $past(lockStatus)})
    else $error("lock register read returns wrong value");

  AST_LOCK_FOLLOWS: assert property (
    ce && lockSync && thirdGenPowerOn |=> lockStatus)
    else $error("lock bit not set while generator locked");

  AST_GEN3_WRITE: assert property (
    ce && busWrite && hit(wbAdr, `IDX_POWER_ENABLE) && wbSel[1]
    |=> thirdGenPowerOn == $past(wbDatI[`BIT_GEN3_PWR]))
    else $error("third generator enable does not follow write");

  AST_GEN2_WRITE: assert property (
    ce && busWrite && hit(wbAdr, `IDX_POWER_ENABLE) && wbSel[1]
    |=> secondGenPowerOn == $past(wbDatI[`BIT_GEN2_PWR]))
    else $error("second generator enable does not follow write");

  genvar a;
  generate
    for (a = 0; a < NPINS; a++) begin : g_pin_chk
      AST_GEN2_PINS: assert property (
        ce && clk_src_t'(bitClockSrc[2*a+:2]) == SRC_GEN2 && !secondGenPowerOn
        |=> !bitClockOutPin[a])
        else $error("bit clock pin toggles from stopped generator");
    end
  endgenerate

  // every function is watched; any function may sit on the system clock and then always runs
  genvar k;
  generate
    for (k = 0; k < NFUNC; k++) begin : g_func_chk
      AST_GEN3_HALT: assert property (
        ce && clk_src_t'(funcClkSrc[2*k+:2]) == SRC_GEN3 && !thirdGenPowerOn |=> !funcRun[k])
        else $error("function runs while third generator stopped");

      AST_GEN2_HALT: assert property (
        ce && clk_src_t'(funcClkSrc[2*k+:2]) == SRC_GEN2 && !secondGenPowerOn
        |=> !funcRun[k])
        else $error("function runs while second generator stopped");

      AST_GEN1_HALT: assert property (
        ce && clk_src_t'(funcClkSrc[2*k+:2]) == SRC_GEN1 && !firstGenPowerOn
        |=> !funcRun[k])
        else $error("function runs while first generator stopped");
    end
  endgenerate

  AST_PWR_RESET: assert property (
    $fell(srst) |-> powerEnable == 16'h0000 && !firstGenPowerOn && !lockStatus)
    else $error("power enable not zero after reset");

  AST_LOCK_OFF: assert property (
    ce && !thirdGenPowerOn |=> !lockStatus)
    else $error("stopped third generator reports lock");

  AST_NO_GAIN_OFF: assert property (
    ce && !thirdGenPowerOn && !lockStatus
    |=> !irqStatus[`BIT_EV_LOCK_GAIN] || $past(irqStatus[`BIT_EV_LOCK_GAIN]))
    else $error("lock gain flagged while third generator stopped");

  AST_ACK_ONE: assert property (
    wbAck |=> !wbAck)
    else $error("ack held for more than one cycle");

  AST_IRQ_LEVEL: assert property (
    ce && |(irqStatus & irqMask) |=> irq)
    else $error("irq low while unmasked status set");

  COV_LOCK_GAIN: cover property (ce && lockEvents[`BIT_EV_LOCK_GAIN]);
  COV_PWR_WRITE: cover property (busWrite && hit(wbAdr, `IDX_POWER_ENABLE));
  COV_IRQ_RISE: cover property ($rose(irq));
  COV_GEN3_STOP: cover property ($fell(thirdGenPowerOn) ##[1:8] !funcRun[NFUNC-1]);

endmodule : audio_clock_gen_power_lock

`default_nettype wire

// File: verif/audio_clock_gen_power_lock_tb.sv
`include "clk_ctrl_defs.svh"
`default_nettype none

module audio_clock_gen_power_lock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clk_ctrl_pkg::*;

  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic ce = 1'h1;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [17:0] wbAdr = 18'h00000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h00000000;
  logic wbAck;
  logic [31:0] wbDatO;
  logic thirdGenLocked = 1'h0;
  gen_vec_t genFrameClk = 3'h7;
  gen_vec_t genBitClk = 3'h7;
  logic firstGenPowerOn;
  logic secondGenPowerOn;
  logic thirdGenPowerOn;
  // pin/function n takes source n: system clock, gen1, gen2, gen3
  logic [7:0] frameClockSrc = 8'hE4;
  logic [7:0] bitClockSrc = 8'hE4;
  logic [7:0] funcClkSrc = 8'hE4;
  logic [3:0] frameClockOutPin;
  logic [3:0] bitClockOutPin;
  logic [3:0] funcRun;
  logic irq;
  int errorCnt = 0;
  int numChecks = 0;
  int cycles = 0;
  logic [31:0] q;

  audio_clock_gen_power_lock i_audio_clock_gen_power_lock (
    .sys_clk(sys_clk), .srst(srst), .ce(ce),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbAck(wbAck), .wbDatO(wbDatO),
    .thirdGenLocked(thirdGenLocked), .genFrameClk(genFrameClk), .genBitClk(genBitClk),
    .firstGenPowerOn(firstGenPowerOn), .secondGenPowerOn(secondGenPowerOn),
    .thirdGenPowerOn(thirdGenPowerOn),
    .frameClockSrc(frameClockSrc), .bitClockSrc(bitClockSrc),
    .frameClockOutPin(frameClockOutPin), .bitClockOutPin(bitClockOutPin),
    .funcClkSrc(funcClkSrc), .funcRun(funcRun), .irq(irq)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // a hang in any wait is cut here rather than by the simulator
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // classic single cycle; the slave decides when ack comes
  task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= {idx, 2'h0};
    wbSel <= 4'h3;
    wbDatI <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'h1);
    rd = wbDatO;
    // taken one edge after the request, ack seen on the next
    check("ack cycles", n, 32'h2);
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
  endtask : wb

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] dummy;
    wb(1'h1, idx, d, dummy);
    idle(3);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wb(1'h0, `IDX_POWER_ENABLE, 16'h0000, q);
    check("power reg", q, 32'h0);
    check("power outs", {29'h0, thirdGenPowerOn, secondGenPowerOn, firstGenPowerOn}, 32'h0);
    wb(1'h0, `IDX_LOCK_STATUS, 16'h0000, q);
    check("lock reg", q, 32'h0);
    wb(1'h0, 16'h1234, 16'h0000, q);
    check("unmapped", q, 32'h0);
    $display("done: reset");
  endtask : t_reset

  task automatic t_power;
    for (int i = 10; i <= 12; i++) begin
      wr(`IDX_POWER_ENABLE, 16'h0001 << i);
      check("gen outs", {29'h0, thirdGenPowerOn, secondGenPowerOn, firstGenPowerOn},
            32'h1 << (i - 10));
    end
    wr(`IDX_POWER_ENABLE, 16'h1800);
    wb(1'h0, `IDX_POWER_ENABLE, 16'h0000, q);
    check("power readback", q, 32'h1800);
    check("gen1 off", {29'h0, thirdGenPowerOn, secondGenPowerOn, firstGenPowerOn}, 32'h6);
    $display("done: power");
  endtask : t_power

  task automatic t_pins;
    logic [15:0] pwr [5] = '{16'h1C00, 16'h1400, 16'h0C00, 16'h1800, 16'h0000};
    logic [3:0] pin [5] = '{4'hE, 4'hA, 4'h6, 4'hC, 4'h0};
    logic [3:0] run [5] = '{4'hF, 4'hB, 4'h7, 4'hD, 4'h1};
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_POWER_ENABLE, pwr[i]);
      idle(3);
      check("frame pins", {28'h0, frameClockOutPin}, {28'h0, pin[i]});
      check("bit pins", {28'h0, bitClockOutPin}, {28'h0, pin[i]});
      check("func run", {28'h0, funcRun}, {28'h0, run[i]});
    end
    wr(`IDX_POWER_ENABLE, 16'h1C00);
    genFrameClk <= 3'h5;
    idle(8);
    check("frame follows", {28'h0, frameClockOutPin}, 32'hA);
    // with the enable low the pins must hold although the clocks move
    ce <= 1'h0;
    genFrameClk <= 3'h7;
    idle(8);
    check("frame frozen", {28'h0, frameClockOutPin}, 32'hA);
    ce <= 1'h1;
    idle(8);
    check("frame resumed", {28'h0, frameClockOutPin}, 32'hE);
    $display("done: pins");
  endtask : t_pins

  task automatic t_lock_irq;
    wr(`IDX_POWER_ENABLE, 16'h1000);
    wr(16'hF060, 16'h0003);
    wr(16'hF061, 16'h0001);
    check("irq idle", {31'h0, irq}, 32'h0);
    thirdGenLocked <= 1'h1;
    idle(10);
    wb(1'h0, `IDX_LOCK_STATUS, 16'h0000, q);
    check("locked", q, 32'h1);
    wr(`IDX_LOCK_STATUS, 16'h0000);
    wb(1'h0, `IDX_LOCK_STATUS, 16'h0000, q);
    check("lock read only", q, 32'h1);
    check("irq gain", {31'h0, irq}, 32'h1);
    wr(16'hF061, 16'h0000);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(16'hF061, 16'h0003);
    wr(16'hF060, 16'h0001);
    wb(1'h0, 16'hF060, 16'h0000, q);
    check("status cleared", q, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    thirdGenLocked <= 1'h0;
    idle(10);
    wb(1'h0, 16'hF060, 16'h0000, q);
    check("status loss", q, 32'h2);
    check("irq loss", {31'h0, irq}, 32'h1);
    thirdGenLocked <= 1'h1;
    idle(10);
    // a stopped generator reads unlocked
    wr(`IDX_POWER_ENABLE, 16'h0000);
    idle(10);
    wb(1'h0, `IDX_LOCK_STATUS, 16'h0000, q);
    check("lock gen3 off", q, 32'h0);
    $display("done: lock and irq");
  endtask : t_lock_irq

  initial begin
    idle(3);
    srst <= 1'h0;
    t_reset();
    t_power();
    t_pins();
    t_lock_irq();
    tally_and_finish();
  end

endmodule : audio_clock_gen_power_lock_tb

`default_nettype wire
